// ==== hdl/ibw_params.svh ====
/*
 * offsets, field positions and reset values of the bus status and wakeup block.
 * assumes an 8-bit register port with an index of four bits.
 */
`ifndef IBW_PARAMS_SVH
`define IBW_PARAMS_SVH

// register indexes
`define IBW_OFS_CTRL 4'h0
`define IBW_OFS_STAT 4'h1
`define IBW_OFS_SADR 4'h2
`define IBW_OFS_IRQS 4'h3
`define IBW_OFS_IMSK 4'h4
`define IBW_OFS_TXD 4'h5
`define IBW_OFS_RXD 4'h6

// control register fields
`define IBW_CTL_EN 7
`define IBW_CTL_REL 6
`define IBW_CTL_STOP_IRQ_ENABLE 5
`define IBW_CTL_WAIT_TIMING_SEL 3
`define IBW_CTL_WAIT_RELEASE_BIT 2
`define IBW_CTL_STA 1

// status register fields
`define IBW_ST_MST 7
`define IBW_ST_ALD 6
`define IBW_ST_EXC 5
`define IBW_ST_MATCH 4
`define IBW_ST_TX 3
`define IBW_ST_WAKE 2

// interrupt status fields
`define IBW_IRQ_BYTE 0
`define IBW_IRQ_STOP 1
`define IBW_IRQ_ARB 2

// reset values
`define IBW_RST_CTRL 8'h00
`define IBW_RST_SADR 8'h00
`define IBW_RST_IMSK 3'h0
`define IBW_RST_TXD 8'hFF

// clock figures of a byte
`define IBW_BIT_8 4'h8
`define IBW_BIT_9 4'h9

`endif

// ==== hdl/ibw_pkg.sv ====
/*
 * types of the bus status and wakeup block.
 * assumes ibw_params.svh is on the include path.
 */
`default_nettype none

package ibw_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } ibw_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ibw_pins_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } ibw_drive_t;

endpackage : ibw_pkg

`default_nettype wire

// ==== hdl/ibw_status_wakeup.sv ====
/*
 * status flags, interrupt timing and slave wakeup filter of a two-wire bus interface.
 * assumes scl and sda come from pins on another clock; one register port on CLK.
 */
// Function
// - extension flag set at eighth rise, 0000/1111
// - extension flag cleared by start, stop, release, disable
// - address match flag set at eighth rise
// - match flag cleared by start, stop, release, disable
// - data line driven only while transmit flag set
// - transmit flag set on master start, slave read
// - transmit flag cleared by stop, release, arbitration loss
// - master read or slave start clears transmit flag
// - wait release clears flag, then releases line
// - arbitration loss interrupts at eighth/ninth fall
// - loss by stop interrupts at stop, enable permitting
// - low line at restart/stop loss: byte-end interrupt
// - timing bit picks ninth or eighth falling edge
// - slave byte-end interrupts only after match, extension or arbitration loss
// - start enters wakeup standby through address
// - stop interrupt follows stop enable regardless of wakeup
// - release bit six, enable bit seven
`include "ibw_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ibw_status_wakeup
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire ibw_pkg::ibw_req_t REQ,
    output logic [7:0] RDATA,
    // bus pins
    input wire ibw_pkg::ibw_pins_t PINS,
    output ibw_pkg::ibw_drive_t DRIVE,
    // interrupt
    output logic IRQ
);
    import ibw_pkg::*;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        logic bus_if_enable;
        logic stop_irq_enable;
        logic wait_timing_sel;
        logic [7:0] local_slave_addr;
        logic [2:0] irq_mask;
        logic [2:0] irq_stat;
        logic [3:0] bit_cnt;
        logic first_byte;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic [7:0] so_latch;
        logic master;
        logic arb_lost_flag;
        logic arb_pend;
        logic ext_code_flag;
        logic addr_match_flag;
        logic tx_status_flag;
        logic wake;
        logic [7:0] rdata;
    } ibw_state_t;

    ibw_state_t s_q;
    ibw_state_t s_d;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic wr_ctrl;
    logic rel_cmd;
    logic wait_release_bit_cmd;
    logic sta_cmd;
    logic en_fall;
    logic flag_clr;
    logic [7:0] addr_byte;
    logic byte_point;
    logic irq_gate;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic arb_hit;

    assign scl = s_q.scl_s[1];
    assign sda = s_q.sda_s[1];
    assign scl_rise = scl & ~s_q.scl_p;
    assign scl_fall = ~scl & s_q.scl_p;
    assign start_det = scl & s_q.scl_p & ~sda & s_q.sda_p;
    assign stop_det = scl & s_q.scl_p & sda & ~s_q.sda_p;

    assign wr_ctrl = REQ.we && (REQ.addr == `IBW_OFS_CTRL);
    assign rel_cmd = wr_ctrl & REQ.wdata[`IBW_CTL_REL];
    assign wait_release_bit_cmd = wr_ctrl & REQ.wdata[`IBW_CTL_WAIT_RELEASE_BIT];
    assign sta_cmd = wr_ctrl & REQ.wdata[`IBW_CTL_STA] & s_q.bus_if_enable;
    assign en_fall = wr_ctrl & s_q.bus_if_enable & ~REQ.wdata[`IBW_CTL_EN];
    assign flag_clr = start_det | stop_det | rel_cmd | en_fall | ~s_q.bus_if_enable;

    // full byte with the bit sampled at the eighth rise
    assign addr_byte = {s_q.rx_shift[6:0], sda};

    // byte-end point picked by the timing bit
    assign byte_point = scl_fall && (s_q.wait_timing_sel ? (s_q.bit_cnt == `IBW_BIT_9)
                                                         : (s_q.bit_cnt == `IBW_BIT_8));

    // released high while master transmitter, but line seen low
    assign arb_hit = s_q.master & s_q.tx_status_flag & s_q.so_latch[7] & scl_rise & ~sda;

    // masters, addressed slaves and losers see byte interrupts
    assign irq_gate = s_q.master | s_q.wake | s_q.arb_pend;

    always_comb
    begin
        irq_set = 3'h0;
        irq_set[`IBW_IRQ_BYTE] = byte_point & irq_gate & s_q.bus_if_enable;
        irq_set[`IBW_IRQ_STOP] = stop_det & s_q.stop_irq_enable & s_q.bus_if_enable;
        irq_set[`IBW_IRQ_ARB] = arb_hit;
        irq_clr = (REQ.re && (REQ.addr == `IBW_OFS_IRQS)) ? 3'h7 : 3'h0;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.scl_s = {s_q.scl_s[0], PINS.scl};
        s_d.sda_s = {s_q.sda_s[0], PINS.sda};
        s_d.scl_p = scl;
        s_d.sda_p = sda;

        // register writes
        if (wr_ctrl)
        begin
            s_d.bus_if_enable = REQ.wdata[`IBW_CTL_EN];
            s_d.stop_irq_enable = REQ.wdata[`IBW_CTL_STOP_IRQ_ENABLE];
            s_d.wait_timing_sel = REQ.wdata[`IBW_CTL_WAIT_TIMING_SEL];
        end
        if (REQ.we && (REQ.addr == `IBW_OFS_SADR))
        begin
            s_d.local_slave_addr = REQ.wdata;
        end
        if (REQ.we && (REQ.addr == `IBW_OFS_IMSK))
        begin
            s_d.irq_mask = REQ.wdata[2:0];
        end
        if (REQ.we && (REQ.addr == `IBW_OFS_TXD))
        begin
            s_d.so_latch = REQ.wdata;
        end

        // bit counter and shifter
        if (start_det | stop_det | ~s_q.bus_if_enable)
        begin
            s_d.bit_cnt = 4'h0;
            s_d.first_byte = 1'b1;
        end
        else if (scl_rise)
        begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            if (s_q.bit_cnt < `IBW_BIT_8)
            begin
                s_d.rx_shift = addr_byte;
            end
        end
        else if (scl_fall)
        begin
            if (s_q.bit_cnt == `IBW_BIT_9)
            begin
                s_d.bit_cnt = 4'h0;
                s_d.first_byte = 1'b0;
                s_d.arb_pend = 1'b0;
            end
            else if (s_q.tx_status_flag && (s_q.bit_cnt != 4'h0) && (s_q.master || ~s_q.first_byte))
            begin
                s_d.so_latch = {s_q.so_latch[6:0], 1'b1};
            end
        end
        if (scl_rise && (s_q.bit_cnt == 4'h7))
        begin
            s_d.rx_data = addr_byte;
        end

        // common clears of the address flags
        if (flag_clr)
        begin
            s_d.ext_code_flag = 1'b0;
            s_d.addr_match_flag = 1'b0;
        end

        // wakeup standby from start through the address byte
        if (start_det | ~s_q.bus_if_enable)
        begin
            s_d.wake = 1'b0;
        end
        if (stop_det)
        begin
            s_d.wake = 1'b0;
        end

        // transmit status clears
        if (stop_det | rel_cmd | en_fall | wait_release_bit_cmd | ~s_q.bus_if_enable)
        begin
            s_d.tx_status_flag = 1'b0;
        end
        if (start_det & ~s_q.master)
        begin
            s_d.tx_status_flag = 1'b0;
        end
        if (~s_q.first_byte & ~s_q.master & ~s_q.addr_match_flag & ~s_q.ext_code_flag)
        begin
            s_d.tx_status_flag = 1'b0;
        end

        // flags taken at the eighth rise of the first byte, set over clear
        if (scl_rise && (s_q.bit_cnt == 4'h7) && s_q.first_byte && s_q.bus_if_enable)
        begin
            if ((addr_byte[7:4] == 4'h0) || (addr_byte[7:4] == 4'hF))
            begin
                s_d.ext_code_flag = 1'b1;
            end
            if (addr_byte[7:1] == s_q.local_slave_addr[7:1])
            begin
                s_d.addr_match_flag = 1'b1;
            end
            if (~s_q.master && ((addr_byte[7:1] == s_q.local_slave_addr[7:1])
                || (addr_byte[7:4] == 4'h0) || (addr_byte[7:4] == 4'hF)))
            begin
                s_d.wake = 1'b1;
            end
            if (s_q.master && addr_byte[0])
            begin
                s_d.tx_status_flag = 1'b0;
            end
            if (~s_q.master && addr_byte[0] && (addr_byte[7:1] == s_q.local_slave_addr[7:1]))
            begin
                s_d.tx_status_flag = 1'b1;
            end
        end

        // arbitration loss turns the master into a slave
        if (arb_hit)
        begin
            s_d.arb_lost_flag = 1'b1;
            s_d.arb_pend = 1'b1;
            s_d.master = 1'b0;
            s_d.tx_status_flag = 1'b0;
        end
        if (stop_det | rel_cmd | ~s_q.bus_if_enable)
        begin
            s_d.master = 1'b0;
            s_d.arb_pend = 1'b0;
        end
        if (REQ.re && (REQ.addr == `IBW_OFS_STAT))
        begin
            s_d.arb_lost_flag = arb_hit;
        end

        // master start command
        if (sta_cmd)
        begin
            s_d.master = 1'b1;
            s_d.tx_status_flag = 1'b1;
        end

        // sticky interrupt bits, set over clear
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

        // read data one cycle after the strobe
        s_d.rdata = 8'h00;
        if (REQ.re)
        begin
            case (REQ.addr)
                `IBW_OFS_CTRL:
                begin
                    s_d.rdata[`IBW_CTL_EN] = s_q.bus_if_enable;
                    s_d.rdata[`IBW_CTL_STOP_IRQ_ENABLE] = s_q.stop_irq_enable;
                    s_d.rdata[`IBW_CTL_WAIT_TIMING_SEL] = s_q.wait_timing_sel;
                end
                `IBW_OFS_STAT:
                begin
                    s_d.rdata[`IBW_ST_MST] = s_q.master;
                    s_d.rdata[`IBW_ST_ALD] = s_q.arb_lost_flag;
                    s_d.rdata[`IBW_ST_EXC] = s_q.ext_code_flag;
                    s_d.rdata[`IBW_ST_MATCH] = s_q.addr_match_flag;
                    s_d.rdata[`IBW_ST_TX] = s_q.tx_status_flag;
                    s_d.rdata[`IBW_ST_WAKE] = s_q.wake;
                end
                `IBW_OFS_SADR:
                begin
                    s_d.rdata = s_q.local_slave_addr;
                end
                `IBW_OFS_IRQS:
                begin
                    s_d.rdata = {5'h00, s_q.irq_stat};
                end
                `IBW_OFS_IMSK:
                begin
                    s_d.rdata = {5'h00, s_q.irq_mask};
                end
                `IBW_OFS_TXD:
                begin
                    s_d.rdata = s_q.so_latch;
                end
                `IBW_OFS_RXD:
                begin
                    s_d.rdata = s_q.rx_data;
                end
                default:
                begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s_q.scl_s <= 2'h3;
            s_q.sda_s <= 2'h3;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.bus_if_enable <= 1'(`IBW_RST_CTRL >> `IBW_CTL_EN);
            s_q.stop_irq_enable <= 1'b0;
            s_q.wait_timing_sel <= 1'b0;
            s_q.local_slave_addr <= `IBW_RST_SADR;
            s_q.irq_mask <= `IBW_RST_IMSK;
            s_q.irq_stat <= 3'h0;
            s_q.bit_cnt <= 4'h0;
            s_q.first_byte <= 1'b1;
            s_q.rx_shift <= 8'h00;
            s_q.rx_data <= 8'h00;
            s_q.so_latch <= `IBW_RST_TXD;
            s_q.master <= 1'b0;
            s_q.arb_lost_flag <= 1'b0;
            s_q.arb_pend <= 1'b0;
            s_q.ext_code_flag <= 1'b0;
            s_q.addr_match_flag <= 1'b0;
            s_q.tx_status_flag <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.rdata <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // data line: driven low only from the latch while transmitting
    always_comb
    begin
        DRIVE.sda_o = 1'b0;
        DRIVE.sda_oe = s_q.tx_status_flag & ~s_q.so_latch[7]
                       & (s_q.master | ~s_q.first_byte);
    end

    assign RDATA = s_q.rdata;
    assign IRQ = |(s_q.irq_stat & s_q.irq_mask);

endmodule : ibw_status_wakeup

`default_nettype wire

// ==== testbench/ibw_bus_peer.sv ====
/* other master on the two-wire bus, 160 ns clock.
   assumes a pull-up on both lines outside this model. */
`timescale 1ns/10ps
`default_nettype none

module ibw_bus_peer
(
    // bus lines
    input wire logic sda_in,
    output logic scl,
    output logic sda_oe
);
    // idle: both lines released, clock stands high
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // data falls while clock high
    task automatic start();
        sda_oe = 1'b1;
        #80;
    endtask : start
    // msb first, ninth clock with data released
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            scl = 1'b0;
            #40 sda_oe = !b[i];
            #40 scl = 1'b1;
            r[i] = sda_in;
            #80;
        end
        scl = 1'b0;
        #40 sda_oe = 1'b0;
        #40 scl = 1'b1;
        #80;
    endtask : xfer
    // data rises while clock high
    task automatic stop();
        scl = 1'b0;
        #40 sda_oe = 1'b1;
        #40 scl = 1'b1;
        #80 sda_oe = 1'b0;
        #80;
    endtask : stop
endmodule : ibw_bus_peer

`default_nettype wire

// ==== testbench/ibw_status_wakeup_checker.sv ====
/* port checker of the status and wakeup block.
   bound to ibw_status_wakeup; pins synchronised here as the block does. */
`include "ibw_params.svh"
`timescale 1ns/10ps
`default_nettype none

module ibw_status_wakeup_checker
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire ibw_pkg::ibw_req_t REQ,
    input wire logic [7:0] RDATA,
    // bus pins
    input wire ibw_pkg::ibw_pins_t PINS,
    input wire ibw_pkg::ibw_drive_t DRIVE,
    // interrupt
    input wire logic IRQ
);
    import ibw_pkg::*;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [7:0] ctl_q;
    logic [2:0] msk_q;
    logic [3:0] cnt_q;
    logic st_q;
    logic sp_q;
    logic rs_q;
    logic start_c;
    logic stop_c;
    logic rise_c;
    assign start_c = scl_q[1] && sda_q[2] && !sda_q[1];
    assign stop_c = scl_q[1] && !sda_q[2] && sda_q[1];
    assign rise_c = scl_q[1] && !scl_q[2];
    // shadows of control, mask, bus events and clock count
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            ctl_q <= 8'h00;
            msk_q <= 3'h0;
            cnt_q <= 4'h0;
            st_q <= 1'b0;
            sp_q <= 1'b0;
            rs_q <= 1'b0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], PINS.scl};
            sda_q <= {sda_q[1:0], PINS.sda};
            if (REQ.we && REQ.addr == `IBW_OFS_CTRL)
                ctl_q <= REQ.wdata;
            if (REQ.we && REQ.addr == `IBW_OFS_IMSK)
                msk_q <= REQ.wdata[2:0];
            rs_q <= REQ.re && REQ.addr == `IBW_OFS_STAT;
            if (start_c)
                cnt_q <= 4'h0;
            else if (rise_c)
                cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            st_q <= start_c || (st_q && !rise_c);
            sp_q <= stop_c || (sp_q && !rise_c && !start_c && !(REQ.we && REQ.addr == `IBW_OFS_CTRL));
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_ctl;
        REQ.we && REQ.addr == `IBW_OFS_CTRL;
    endsequence
    sequence s_rd_st;
        REQ.re && REQ.addr == `IBW_OFS_STAT;
    endsequence
    property p_rel_clr;
        s_ctl ##0 REQ.wdata[`IBW_CTL_REL] ##[1:3] s_rd_st |=> RDATA[5:3] == 3'h0;
    endproperty
    a_rel_clr: assert property (p_rel_clr)
        else $error("flags kept after release");
    property p_wait_release_bit;
        s_ctl ##0 REQ.wdata[2] |=> !DRIVE.sda_oe;
    endproperty
    a_wait_release_bit: assert property (p_wait_release_bit)
        else $error("data line held after wait release");
    property p_dis_drive;
        s_ctl ##0 !REQ.wdata[`IBW_CTL_EN] |=> !DRIVE.sda_oe [*3];
    endproperty
    a_dis_drive: assert property (p_dis_drive)
        else $error("data line driven while disabled");
    property p_dis_flags;
        rs_q && !ctl_q[`IBW_CTL_EN] |-> RDATA[5:3] == 3'h0;
    endproperty
    a_dis_flags: assert property (p_dis_flags)
        else $error("flags set while disabled");
    property p_start_clr;
        rs_q && st_q |-> RDATA[5:4] == 2'h0 && (RDATA[7] || !RDATA[3]);
    endproperty
    a_start_clr: assert property (p_start_clr)
        else $error("flags kept after start");
    property p_stop_clr;
        rs_q && sp_q |-> RDATA[5:3] == 3'h0;
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("flags kept after stop");
    property p_stop_irq;
        stop_c && ctl_q[7] && ctl_q[5] && msk_q[1] |-> ##[1:4] IRQ;
    endproperty
    a_stop_irq: assert property (p_stop_irq)
        else $error("no interrupt at stop");
    property p_byte_irq;
        $rose(IRQ) && msk_q == 3'h1 |-> cnt_q == (ctl_q[3] ? 4'h9 : 4'h8);
    endproperty
    a_byte_irq: assert property (p_byte_irq)
        else $error("byte interrupt at wrong clock");
endmodule : ibw_status_wakeup_checker

bind ibw_status_wakeup ibw_status_wakeup_checker u_ibw_status_wakeup_checker (.CLK(CLK), .SYS_RST(SYS_RST),
    .REQ(REQ), .RDATA(RDATA), .PINS(PINS), .DRIVE(DRIVE), .IRQ(IRQ));

`default_nettype wire

// ==== testbench/test_ibw_status_wakeup.sv ====
/* bench of the status and wakeup block: register tasks and a bus peer.
   assumes the peer model and the bound checker are compiled alongside. */
`include "ibw_params.svh"
`timescale 1ns/10ps
`default_nettype none

module test_ibw_status_wakeup;
    import ibw_pkg::*;
    logic clk;
    logic rst;
    logic irq;
    logic scl;
    logic p_oe;
    logic [7:0] rdata;
    logic [7:0] r;
    wire logic sda;
    ibw_req_t req;
    ibw_pins_t pins;
    ibw_drive_t drv;
    int n_fail;
    int num_checks;
    // ctrl, address byte, expected status bits 5:2
    logic [23:0] tbl [5] = '{24'h80A414, 24'h88A414, 24'h800824, 24'h80F624, 24'h886000};
    assign sda = !(p_oe || (drv.sda_oe && !drv.sda_o));
    assign pins = {scl, sda};
    ibw_status_wakeup u_ibw_status_wakeup (.CLK(clk), .SYS_RST(rst), .REQ(req), .RDATA(rdata),
        .PINS(pins), .DRIVE(drv), .IRQ(irq));
    ibw_bus_peer u_ibw_bus_peer (.sda_in(sda), .scl(scl), .sda_oe(p_oe));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        req.we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        req.re <= 1'b0;
        #1;
        cmp(rdata & m, e);
    endtask : rd
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        rst = 1'b1;
        req = '0;
        n_fail = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`IBW_OFS_CTRL, 8'hFF, `IBW_RST_CTRL);
        rd(`IBW_OFS_SADR, 8'hFF, `IBW_RST_SADR);
        rd(`IBW_OFS_TXD, 8'hFF, `IBW_RST_TXD);
        rd(4'hF, 8'hFF, 8'h00);
        wr(`IBW_OFS_SADR, 8'hA4);
        wr(`IBW_OFS_IMSK, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            wr(`IBW_OFS_CTRL, tbl[i][23:16]);
            u_ibw_bus_peer.start();
            rd(`IBW_OFS_STAT, 8'h3C, 8'h00);
            u_ibw_bus_peer.xfer(tbl[i][15:8], r);
            rd(`IBW_OFS_STAT, 8'h3C, tbl[i][7:0]);
            u_ibw_bus_peer.stop();
            cmp({7'h00, irq}, {7'h00, |tbl[i][7:0]});
            rd(`IBW_OFS_IRQS, 8'h07, {7'h00, |tbl[i][7:0]});
            rd(`IBW_OFS_STAT, 8'h38, 8'h00);
        end
        // master start, then loses the first bit to the peer
        wr(`IBW_OFS_IMSK, 8'h04);
        wr(`IBW_OFS_TXD, 8'hFF);
        wr(`IBW_OFS_CTRL, 8'h82);
        rd(`IBW_OFS_STAT, 8'h88, 8'h88);
        u_ibw_bus_peer.start();
        u_ibw_bus_peer.xfer(8'h40, r);
        cmp({7'h00, irq}, 8'h01);
        rd(`IBW_OFS_STAT, 8'hC8, 8'h40);
        rd(`IBW_OFS_IRQS, 8'h07, 8'h05);
        u_ibw_bus_peer.stop();
        wr(`IBW_OFS_IMSK, 8'h02);
        wr(`IBW_OFS_TXD, 8'h00);
        wr(`IBW_OFS_CTRL, 8'hA0);
        u_ibw_bus_peer.start();
        u_ibw_bus_peer.xfer(8'hA5, r);
        rd(`IBW_OFS_STAT, 8'h1C, 8'h1C);
        u_ibw_bus_peer.xfer(8'hFF, r);
        cmp(r, 8'h00);
        wr(`IBW_OFS_CTRL, 8'hA4);
        rd(`IBW_OFS_STAT, 8'h08, 8'h00);
        wr(`IBW_OFS_CTRL, 8'hE0);
        rd(`IBW_OFS_STAT, 8'h38, 8'h00);
        u_ibw_bus_peer.stop();
        cmp({7'h00, irq}, 8'h01);
        rd(`IBW_OFS_IRQS, 8'h02, 8'h02);
        wr(`IBW_OFS_CTRL, 8'h00);
        rd(`IBW_OFS_STAT, 8'h38, 8'h00);
        conclude();
    end
endmodule : test_ibw_status_wakeup

`default_nettype wire
